/* File: hdl/pmm_phy_end.sv */
// phy end of the mii: link clocks, data paths, carrier, collision, management slave
`timescale 1ns/1ps
`default_nettype none
module pmm_phy_end (
  input wire logic core_clk,
  input wire logic rst_b,
  pmm_if.phy link,
  input wire logic [3:0] rxNibble,
  input wire logic rxValid,
  input wire logic rxError,
  input wire logic carrier,
  input wire logic collision,
  input wire logic statusEvent,
  input wire logic mgmtPortDisable,
  input wire logic cfgFullDuplex,
  input wire logic cfgSpeed100,
  input wire logic [4:0] phyAddr,
  output logic [3:0] txNibble,
  output logic txValid,
  output logic txError,
  output logic txStrobe,
  output logic rxTake,
  output logic fullDuplex,
  output logic speed100
);
  import pmm_pkg::*;

  logic [15:0] ctrl;
  logic irqEn;
  logic irqPend;
  logic irqOe;
  logic [3:0] divCnt;
  logic [3:0] halfCnt;
  logic linkClk;
  logic divWrap;
  logic linkRise;
  logic linkFall;
  logic [1:0] riseDly;
  logic [5:0] txS1;
  logic [5:0] txS2;
  logic [7:0] strapS1;
  logic [7:0] strapS2;
  logic [1:0] mdS1;
  logic [1:0] mdS2;
  logic mdcPrev;
  logic mdcRise;
  logic mdBit;
  logic [3:0] rxdReg;
  logic rxDvReg;
  logic rxErReg;
  logic crsReg;
  logic colReg;
  pmm_mdstate_t mdState;
  logic [5:0] ones;
  logic [4:0] bitCnt;
  logic [15:0] shiftIn;
  logic [15:0] rdShift;
  logic [12:0] hdr;
  logic isWrite;
  logic [4:0] regSel;
  logic mdioOut;
  logic mdioOe;
  logic wrEn;
  logic [15:0] wrData;
  logic rdClr;
  logic [15:0] rdVal;

  assign fullDuplex = ctrl[CTRL_DUPLEX_BIT];
  assign speed100 = ctrl[CTRL_SPEED_BIT];

  // shared divider
  // a 10 MHz core cannot reach 25 MHz; the fast mode runs at the divider floor
  assign halfCnt = speed100 ? LINK_HALF_100 : LINK_HALF_10;
  assign divWrap = (divCnt == halfCnt - 4'h1);
  assign linkRise = divWrap & ~linkClk;
  assign linkFall = divWrap & linkClk;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      divCnt <= 4'h0;
      linkClk <= 1'b0;
    end else if (divWrap) begin
      divCnt <= 4'h0;
      linkClk <= ~linkClk;
    end else begin
      divCnt <= divCnt + 4'h1;
    end
  end
  assign link.txClk = linkClk;
  assign link.rxClk = linkClk;

  // synchronisers for pins from the far end and the straps
  always_ff @(posedge core_clk) begin
    txS1 <= {link.txEr, link.txEn, link.txd};
    txS2 <= txS1;
    strapS1 <= {mgmtPortDisable, cfgFullDuplex, cfgSpeed100, phyAddr};
    strapS2 <= strapS1;
    mdS1 <= {link.mdc, link.mdio};
    mdS2 <= mdS1;
  end

  // sample pins as they stood at our rising edge
  // the delay matches the two synchroniser stages
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      riseDly <= 2'h0;
      txNibble <= 4'h0;
      txValid <= 1'b0;
      txError <= 1'b0;
      txStrobe <= 1'b0;
    end else begin
      riseDly <= {riseDly[0], linkRise};
      txStrobe <= riseDly[1];
      if (riseDly[1]) begin
        txNibble <= txS2[3:0];
        txValid <= txS2[4];
        txError <= txS2[5];
      end
    end
  end

  // receive pins change on the falling edge
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rxdReg <= 4'h0;
      rxDvReg <= 1'b0;
      rxErReg <= 1'b0;
      rxTake <= 1'b0;
    end else begin
      rxTake <= linkFall;
      if (linkFall) begin
        rxdReg <= rxValid ? rxNibble : 4'h0;
        rxDvReg <= rxValid;
        rxErReg <= rxError;
      end
    end
  end
  assign link.rxd = rxdReg;
  assign link.rxDv = rxDvReg;
  assign link.rxEr = rxErReg;

  // carrier sets at once, clears only on a receive clock edge
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      crsReg <= 1'b0;
    end else if (carrier | (~fullDuplex & txS2[4])) begin
      crsReg <= 1'b1;
    end else if (linkFall) begin
      crsReg <= 1'b0;
    end
  end

  // collision follows the line in half duplex, not the link clock; full duplex holds it low
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      colReg <= 1'b0;
    end else begin
      colReg <= collision & ~fullDuplex;
    end
  end
  assign link.crs = crsReg;
  assign link.col = colReg;

  // management slave, sampled on management clock rise
  assign mdcRise = mdS2[1] & ~mdcPrev;
  assign mdBit = mdS2[0];
  assign hdr = {shiftIn[11:0], mdBit};
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mdcPrev <= 1'b0;
      mdState <= MD_PRE;
      ones <= 6'h0;
      bitCnt <= 5'h0;
      shiftIn <= 16'h0;
      rdShift <= 16'h0;
      isWrite <= 1'b0;
      regSel <= 5'h0;
      mdioOut <= 1'b0;
      mdioOe <= 1'b0;
      wrEn <= 1'b0;
      wrData <= 16'h0;
      rdClr <= 1'b0;
    end else begin
      mdcPrev <= mdS2[1];
      wrEn <= 1'b0;
      rdClr <= 1'b0;
      if (mdcRise) begin
        case (mdState)
          MD_PRE: begin
            if (mdBit) begin
              ones <= (ones == PREAMBLE_LEN) ? ones : ones + 6'h1;
            end else begin
              ones <= 6'h0;
              if (ones == PREAMBLE_LEN) begin
                mdState <= MD_HDR;
                bitCnt <= 5'h0;
              end
            end
          end
          MD_HDR: begin
            shiftIn <= {shiftIn[14:0], mdBit};
            bitCnt <= bitCnt + 5'h1;
            if (bitCnt == HDR_BITS - 5'h1) begin
              bitCnt <= 5'h0;
              regSel <= hdr[4:0];
              isWrite <= (hdr[11:10] == OP_WRITE);
              // disabled port or foreign address: drop the frame
              if (hdr[12] && !strapS2[7] && hdr[9:5] == strapS2[4:0] &&
                  (hdr[11:10] == OP_READ || hdr[11:10] == OP_WRITE)) begin
                mdState <= MD_TA;
              end else begin
                mdState <= MD_PRE;
              end
            end
          end
          MD_TA: begin
            bitCnt <= bitCnt + 5'h1;
            if (bitCnt == 5'h0 && !isWrite) begin
              mdioOe <= 1'b1;
              mdioOut <= 1'b0;
              rdShift <= rdVal;
              // reading the status register clears it
              rdClr <= (regSel == REG_IRQ_STAT);
            end
            if (bitCnt == TA_BITS - 5'h1) begin
              bitCnt <= 5'h0;
              mdState <= isWrite ? MD_WR : MD_RD;
              if (!isWrite) begin
                mdioOut <= rdShift[15];
                rdShift <= {rdShift[14:0], 1'b0};
              end
            end
          end
          MD_RD: begin
            bitCnt <= bitCnt + 5'h1;
            if (bitCnt == DATA_BITS - 5'h1) begin
              mdioOe <= 1'b0;
              mdState <= MD_PRE;
            end else begin
              mdioOut <= rdShift[15];
              rdShift <= {rdShift[14:0], 1'b0};
            end
          end
          MD_WR: begin
            shiftIn <= {shiftIn[14:0], mdBit};
            bitCnt <= bitCnt + 5'h1;
            if (bitCnt == DATA_BITS - 5'h1) begin
              wrEn <= 1'b1;
              wrData <= {shiftIn[14:0], mdBit};
              mdState <= MD_PRE;
            end
          end
          default: begin
            mdState <= MD_PRE;
            mdioOe <= 1'b0;
          end
        endcase
      end
    end
  end
  assign link.mdioPhyOut = mdioOut;
  assign link.mdioPhyOe = mdioOe;

  always_comb begin
    rdVal = 16'h0;
    case (regSel)
      REG_CTRL: rdVal = ctrl;
      REG_IRQ_EN: rdVal[IRQ_EN_BIT] = irqEn;
      REG_IRQ_STAT: rdVal[IRQ_STAT_BIT] = irqPend;
      default: rdVal = 16'h0;
    endcase
  end

  // straps load defaults during reset; afterwards only frames write
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ctrl <= 16'h0;
      ctrl[CTRL_DUPLEX_BIT] <= strapS2[6];
      ctrl[CTRL_SPEED_BIT] <= strapS2[5];
      irqEn <= 1'b0;
    end else if (wrEn) begin
      if (regSel == REG_CTRL) begin
        ctrl <= wrData;
      end
      if (regSel == REG_IRQ_EN) begin
        irqEn <= wrData[IRQ_EN_BIT];
      end
    end
  end

  // pending flag, a new event beats a clearing read
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      irqPend <= 1'b0;
      irqOe <= 1'b0;
    end else begin
      if (statusEvent) begin
        irqPend <= 1'b1;
      end else if (rdClr) begin
        irqPend <= 1'b0;
      end
      irqOe <= irqEn & irqPend;
    end
  end
  assign link.statusChangeIrqNOut = 1'b0;
  assign link.statusChangeIrqNOe = irqOe;
endmodule
`default_nettype wire

/* File: hdl/pmm_pkg.sv */
// shared constants for the mii data and management port
`default_nettype none
package pmm_pkg;
  localparam int CORE_HZ = 10_000_000;
  localparam int LINK_HZ_10 = 2_500_000;
  localparam int LINK_HZ_100 = 25_000_000;
  localparam int MDC_MAX_HZ = 8_000_000;
  localparam int MDC_HZ = 1_250_000;
  // half periods of the link clocks in core cycles, never below one
  localparam int LINK_HALF_10_I = CORE_HZ / (2 * LINK_HZ_10);
  localparam int LINK_HALF_100_I = CORE_HZ / (2 * LINK_HZ_100);
  localparam logic [3:0] LINK_HALF_10 = 4'((LINK_HALF_10_I < 1) ? 1 : LINK_HALF_10_I);
  localparam logic [3:0] LINK_HALF_100 = 4'((LINK_HALF_100_I < 1) ? 1 : LINK_HALF_100_I);
  localparam int MDC_HALF_I = (MDC_HZ > MDC_MAX_HZ) ? 1 : CORE_HZ / (2 * MDC_HZ);
  localparam logic [3:0] MDC_HALF = 4'((MDC_HALF_I < 1) ? 1 : MDC_HALF_I);

  // management frame layout
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [31:0] PREAMBLE_BITS = 32'hffffffff;
  localparam logic [1:0] START_BITS = 2'h1;
  localparam logic [4:0] HDR_BITS = 5'hd;
  localparam logic [4:0] TA_BITS = 5'h2;
  localparam logic [4:0] DATA_BITS = 5'h10;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] TA_WRITE = 2'h2;
  localparam logic [5:0] FRAME_TA_BIT = 6'h2e;
  localparam logic [5:0] FRAME_DATA_BIT = 6'h30;
  localparam logic [5:0] FRAME_LAST = 6'h3f;

  // device management registers
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_IRQ_EN = 5'h12;
  localparam logic [4:0] REG_IRQ_STAT = 5'h13;
  localparam int CTRL_DUPLEX_BIT = 8;
  localparam int CTRL_SPEED_BIT = 13;
  localparam int IRQ_EN_BIT = 1;
  localparam int IRQ_STAT_BIT = 2;

  // station registers on axi4-lite
  localparam int AXI_ADDR_W = 4;
  localparam logic [3:0] ADDR_CMD = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam int CMD_REG_LSB = 16;
  localparam int CMD_PHY_LSB = 21;
  localparam int CMD_RD_BIT = 26;
  localparam int STAT_BUSY_BIT = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] STRB_ALL = 4'hf;

  typedef enum logic [2:0] {
    MD_PRE = 3'b000,
    MD_HDR = 3'b001,
    MD_TA = 3'b010,
    MD_RD = 3'b011,
    MD_WR = 3'b100
  } pmm_mdstate_t;
endpackage
`default_nettype wire

/* File: hdl/pmm_if.sv */
// mii pins between the phy end and the mac/station end
`timescale 1ns/1ps
`default_nettype none
interface pmm_if;
  logic txClk;
  logic rxClk;
  logic [3:0] txd;
  logic txEn;
  logic txEr;
  logic [3:0] rxd;
  logic rxDv;
  logic rxEr;
  logic crs;
  logic col;
  logic mdc;
  logic mdioPhyOut;
  logic mdioPhyOe;
  logic mdioStaOut;
  logic mdioStaOe;
  logic mdio;
  logic statusChangeIrqNOut;
  logic statusChangeIrqNOe;
  logic statusChangeIrqN;
  // pull-ups model the idle level of the shared and open-drain lines
  assign mdio = mdioPhyOe ? mdioPhyOut : (mdioStaOe ? mdioStaOut : 1'b1);
  assign statusChangeIrqN = statusChangeIrqNOe ? statusChangeIrqNOut : 1'b1;
  modport phy (
    output txClk, rxClk, rxd, rxDv, rxEr, crs, col,
    output mdioPhyOut, mdioPhyOe, statusChangeIrqNOut, statusChangeIrqNOe,
    input txd, txEn, txEr, mdc, mdio
  );
  modport mac (
    output txd, txEn, txEr, mdc, mdioStaOut, mdioStaOe,
    input txClk, rxClk, rxd, rxDv, rxEr, crs, col, mdio, statusChangeIrqN
  );
endinterface
`default_nettype wire

/* File: hdl/pmm_mac_end.sv */
// mac and management station end of the mii, commanded over axi4-lite
`timescale 1ns/1ps
`default_nettype none
module pmm_mac_end (
  input wire logic core_clk,
  input wire logic rst_b,
  pmm_if.mac link,
  input wire logic [pmm_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pmm_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] txData,
  input wire logic txValid,
  input wire logic txErr,
  output logic txReady,
  output logic [3:0] rxData,
  output logic rxValid,
  output logic rxErr,
  output logic rxStrobe,
  output logic carrierSense,
  output logic collisionSeen,
  output logic irqPending
);
  import pmm_pkg::*;

  // pin sync bits: 0 txClk, 1 rxClk, 5:2 rxd, 6 rxDv, 7 rxEr, 8 crs, 9 col, 10 mdio, 11 irq
  logic [11:0] s1;
  logic [11:0] s2;
  logic txClkPrev;
  logic rxClkPrev;
  logic txRise;
  logic rxRise;
  logic [3:0] mdcCnt;
  logic mdc;
  logic mdcWrap;
  logic mdcRiseE;
  logic mdcFallE;
  logic [AXI_ADDR_W-1:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic [31:0] cmdReg;
  logic startReq;
  logic busy;
  logic started;
  logic isRead;
  logic [63:0] frame;
  logic [5:0] curBit;
  logic [15:0] rdData;
  logic mdioOut;
  logic mdioOe;

  always_ff @(posedge core_clk) begin
    s1 <= {link.statusChangeIrqN, link.mdio, link.col, link.crs, link.rxEr, link.rxDv,
           link.rxd, link.rxClk, link.txClk};
    s2 <= s1;
  end
  assign txRise = s2[0] & ~txClkPrev;
  assign rxRise = s2[1] & ~rxClkPrev;

  // drive a new nibble three core cycles after each transmit clock rise, once the rise is through the synchroniser
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      txClkPrev <= 1'b0;
      link.txd <= 4'h0;
      link.txEn <= 1'b0;
      link.txEr <= 1'b0;
      txReady <= 1'b0;
    end else begin
      txClkPrev <= s2[0];
      txReady <= txRise & txValid;
      if (txRise) begin
        link.txd <= txValid ? txData : 4'h0;
        link.txEn <= txValid;
        link.txEr <= txErr & txValid;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rxClkPrev <= 1'b0;
      rxData <= 4'h0;
      rxValid <= 1'b0;
      rxErr <= 1'b0;
      rxStrobe <= 1'b0;
      carrierSense <= 1'b0;
      collisionSeen <= 1'b0;
      irqPending <= 1'b0;
    end else begin
      rxClkPrev <= s2[1];
      rxStrobe <= rxRise;
      if (rxRise) begin
        rxData <= s2[5:2];
        rxValid <= s2[6];
        rxErr <= s2[7];
      end
      carrierSense <= s2[8];
      collisionSeen <= s2[9];
      irqPending <= ~s2[11];
    end
  end

  // management clock divided well below its ceiling
  assign mdcWrap = (mdcCnt == MDC_HALF - 4'h1);
  assign mdcRiseE = mdcWrap & ~mdc;
  assign mdcFallE = mdcWrap & mdc;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mdcCnt <= 4'h0;
      mdc <= 1'b0;
    end else if (mdcWrap) begin
      mdcCnt <= 4'h0;
      mdc <= ~mdc;
    end else begin
      mdcCnt <= mdcCnt + 4'h1;
    end
  end
  assign link.mdc = mdc;

  // axi4-lite slave; one write and one read in flight at most
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awAddr <= '0;
      wData <= 32'h0;
      wStrb <= 4'h0;
      cmdReg <= 32'h0;
      startReq <= 1'b0;
    end else begin
      startReq <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr == ADDR_CMD || awAddr == ADDR_STAT) ? RESP_OKAY : RESP_SLVERR;
        // a command while busy is dropped; software polls busy first
        if (awAddr == ADDR_CMD && wStrb == STRB_ALL && !busy) begin
          cmdReg <= wData;
          startReq <= 1'b1;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr == ADDR_CMD) begin
        s_axi_rdata <= cmdReg;
      end else if (s_axi_araddr == ADDR_STAT) begin
        s_axi_rdata <= {15'h0, busy, rdData};
      end else begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // frame shifted out on falls, read data taken on rises
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      busy <= 1'b0;
      started <= 1'b0;
      isRead <= 1'b0;
      frame <= 64'h0;
      curBit <= 6'h0;
      rdData <= 16'h0;
      mdioOut <= 1'b1;
      mdioOe <= 1'b0;
    end else if (startReq) begin
      busy <= 1'b1;
      started <= 1'b0;
      isRead <= cmdReg[CMD_RD_BIT];
      frame <= {PREAMBLE_BITS, START_BITS,
                cmdReg[CMD_RD_BIT] ? OP_READ : OP_WRITE,
                cmdReg[CMD_PHY_LSB +: 5], cmdReg[CMD_REG_LSB +: 5],
                cmdReg[CMD_RD_BIT] ? 2'h3 : TA_WRITE,
                cmdReg[CMD_RD_BIT] ? 16'hffff : cmdReg[15:0]};
    end else if (busy && mdcFallE) begin
      if (started && curBit == FRAME_LAST) begin
        busy <= 1'b0;
        mdioOe <= 1'b0;
      end else begin
        started <= 1'b1;
        curBit <= started ? curBit + 6'h1 : 6'h0;
        mdioOut <= frame[63];
        frame <= {frame[62:0], 1'b0};
        // on a read, hand the line over to the phy from the turnaround onward; a write keeps driving
        mdioOe <= ~(isRead && started && curBit + 6'h1 >= FRAME_TA_BIT);
      end
    end else if (busy && mdcRiseE && started && isRead && curBit >= FRAME_DATA_BIT) begin
      rdData <= {rdData[14:0], s2[10]};
    end
  end
  assign link.mdioStaOut = mdioOut;
  assign link.mdioStaOe = mdioOe;
endmodule
`default_nettype wire

/* File: testbench/pmm_link_chk.sv */
// concurrent checks on the mii pins between the two ends
`timescale 1ns/1ps
`default_nettype none
module pmm_link_chk (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic txClk,
  input wire logic rxClk,
  input wire logic [3:0] txd,
  input wire logic txEn,
  input wire logic txEr,
  input wire logic [3:0] rxd,
  input wire logic rxDv,
  input wire logic rxEr,
  input wire logic crs,
  input wire logic col,
  input wire logic mdc,
  input wire logic mdioPhyOe,
  input wire logic mdioStaOe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  AST_TXD_HOLD: assert property ($rose(txClk) |-> $stable(txd) [*2])
    else $error("txd moved at tx clock rise");
  AST_TXEN_HOLD: assert property ($rose(txClk) |-> $stable({txEn, txEr}) [*2])
    else $error("tx enable or error moved at tx clock rise");
  AST_RX_SYNC: assert property (!$stable({rxd, rxDv, rxEr}) |-> !rxClk)
    else $error("rx pins moved outside rx clock low phase");
  AST_TXCLK_RATE: assert property ($rose(txClk) |-> txClk [*2] ##1 !txClk [*2] ##1 txClk)
    else $error("tx clock period wrong");
  AST_RXCLK_RATE: assert property ($rose(rxClk) |-> rxClk [*2] ##1 !rxClk [*2] ##1 rxClk)
    else $error("rx clock period wrong");
  AST_CRS_FALL: assert property ($fell(crs) |-> !rxClk)
    else $error("carrier dropped off the rx clock fall");
  AST_MDIO_ONE: assert property (!(mdioPhyOe && mdioStaOe))
    else $error("both ends drive the management line");
  AST_MDC_SLOW: assert property ($rose(mdc) |-> mdc [*4])
    else $error("management clock high phase too short");
  cover property ($rose(rxDv));
  cover property ($rose(col));
  cover property ($rose(mdioPhyOe));
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// bench: both ends joined over the mii, station driven over axi4-lite
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pmm_pkg::*;
  logic core_clk = 0, rst_b = 0;
  logic [3:0] rxNibble = 0, txData = 0, awaddr = 0, araddr = 0, txNibble, rxData;
  logic rxValid = 0, rxError = 0, carrier = 0, collision = 0, statusEvent = 0, mdis = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, macTxValid = 0, txErr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, phyTxValid, txError, txStrobe, rxTake;
  logic fullDuplex, speed100, txReady, macRxValid, rxErr, rxStrobe, carrierSense, collisionSeen;
  logic irqPending;
  logic [4:0] txQ[$], rxQ[$];
  int err_total = 0, n_checks = 0, seed = 32'hadd6, txLeft = 0, rxLeft = 0;
  always #50 core_clk = ~core_clk;
  pmm_if link ();
  pmm_phy_end i_pmm_phy_end (.core_clk(core_clk), .rst_b(rst_b), .link(link.phy),
    .rxNibble(rxNibble), .rxValid(rxValid), .rxError(rxError), .carrier(carrier),
    .collision(collision), .statusEvent(statusEvent), .mgmtPortDisable(mdis),
    .cfgFullDuplex(1'b1), .cfgSpeed100(1'b0), .phyAddr(5'h05), .txNibble(txNibble),
    .txValid(phyTxValid), .txError(txError), .txStrobe(txStrobe), .rxTake(rxTake),
    .fullDuplex(fullDuplex), .speed100(speed100));
  pmm_mac_end i_pmm_mac_end (.core_clk(core_clk), .rst_b(rst_b), .link(link.mac),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(STRB_ALL), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .txData(txData), .txValid(macTxValid),
    .txErr(txErr), .txReady(txReady), .rxData(rxData), .rxValid(macRxValid), .rxErr(rxErr),
    .rxStrobe(rxStrobe), .carrierSense(carrierSense), .collisionSeen(collisionSeen),
    .irqPending(irqPending));
  pmm_link_chk i_pmm_link_chk (.core_clk(core_clk), .rst_b(rst_b), .txClk(link.txClk),
    .rxClk(link.rxClk), .txd(link.txd), .txEn(link.txEn), .txEr(link.txEr), .rxd(link.rxd),
    .rxDv(link.rxDv), .rxEr(link.rxEr), .crs(link.crs), .col(link.col), .mdc(link.mdc),
    .mdioPhyOe(link.mdioPhyOe), .mdioStaOe(link.mdioStaOe));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tmo;
    check("wait limit", 0, 1);
    results;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic axiWr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (n == 99) tmo;
    @(posedge core_clk);
  endtask
  task automatic axiRd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 99) tmo;
    @(posedge core_clk);
  endtask
  // station command, then poll busy until the frame is over
  task automatic mgmt(input logic rd, input logic [4:0] pa, ra, input logic [15:0] d,
                      output logic [15:0] q);
    logic [31:0] v;
    logic [1:0] r;
    int n;
    axiWr(ADDR_CMD, {5'h00, rd, pa, ra, d}, r);
    for (n = 0; n < 400; n++) begin
      axiRd(ADDR_STAT, v, r);
      if (!v[STAT_BUSY_BIT]) break;
    end
    q = v[15:0];
    if (n == 400) tmo;
  endtask
  task automatic go(input int k);
    txLeft <= k;
    rxLeft <= k;
    txData <= 4'($random(seed));
    rxNibble <= 4'($random(seed));
    macTxValid <= 1'b1;
    rxValid <= 1'b1;
  endtask
  task automatic drain;
    int n;
    for (n = 0; n < 400 && (txLeft + rxLeft + txQ.size() + rxQ.size() != 0); n++)
      @(posedge core_clk);
    if (n == 400) tmo;
  endtask
  always @(posedge core_clk) begin
    if (macTxValid && txReady) begin
      txQ.push_back({txErr, txData});
      txLeft <= txLeft - 1;
      macTxValid <= txLeft > 1;
      txData <= 4'($random(seed));
      txErr <= $random(seed) % 5 == 0;
    end
    if (rxValid && rxTake) begin
      rxQ.push_back({rxError, rxNibble});
      rxLeft <= rxLeft - 1;
      rxValid <= rxLeft > 1;
      rxNibble <= 4'($random(seed));
      rxError <= $random(seed) % 5 == 0;
    end
  end
  always @(posedge core_clk) begin
    if (txStrobe && phyTxValid) check("tx nibble", {txError, txNibble}, txQ.pop_front());
    if (rxStrobe && macRxValid) check("rx nibble", {rxErr, rxData}, rxQ.pop_front());
  end
  initial begin
    logic [15:0] q;
    logic [31:0] v;
    logic [1:0] r;
    idle(4);
    rst_b <= 1'b1;
    idle(1);
    mgmt(1'b1, 5'h05, REG_CTRL, 16'h0000, q);
    check("strap duplex", q[CTRL_DUPLEX_BIT], 1);
    check("strap speed", speed100, 0);
    collision <= 1'b1;
    carrier <= 1'b1;
    idle(10);
    check("fd collision", collisionSeen, 0);
    check("fd rx carrier", carrierSense, 1);
    carrier <= 1'b0;
    go(12);
    idle(24);
    check("fd tx carrier", carrierSense, 0);
    drain;
    collision <= 1'b0;
    mgmt(1'b0, 5'h05, REG_CTRL, 16'h0000, q);
    check("duplex written", fullDuplex, 0);
    go(12);
    idle(24);
    check("hd tx carrier", carrierSense, 1);
    drain;
    collision <= 1'b1;
    idle(10);
    check("hd collision", collisionSeen, 1);
    collision <= 1'b0;
    idle(10);
    check("collision end", collisionSeen, 0);
    mdis <= 1'b1;
    mgmt(1'b0, 5'h05, REG_CTRL, 16'h0100, q);
    check("disabled write", fullDuplex, 0);
    mgmt(1'b1, 5'h05, REG_CTRL, 16'h0000, q);
    check("disabled read", q, 16'hffff);
    mdis <= 1'b0;
    mgmt(1'b1, 5'h06, REG_CTRL, 16'h0000, q);
    check("other address", q, 16'hffff);
    mgmt(1'b0, 5'h05, REG_IRQ_EN, 16'(1 << IRQ_EN_BIT), q);
    statusEvent <= 1'b1;
    idle(1);
    statusEvent <= 1'b0;
    idle(8);
    check("irq line", link.statusChangeIrqN, 0);
    check("irq seen", irqPending, 1);
    mgmt(1'b1, 5'h05, REG_IRQ_STAT, 16'h0000, q);
    check("irq status", q[IRQ_STAT_BIT], 1);
    idle(8);
    check("irq released", link.statusChangeIrqN, 1);
    axiRd(4'h8, v, r);
    check("unmapped read", r, RESP_SLVERR);
    axiWr(4'hc, 32'h0000_0000, r);
    check("unmapped write", r, RESP_SLVERR);
    results;
  end
endmodule
`default_nettype wire
